//--- lad_line_alarm_detector.sv
`default_nettype none
module lad_line_alarm_detector #(
    parameter int unsigned E1_HOLD_CYCLES = lad_pkg::CF_E1_CYCLES,
    parameter int unsigned T1_WIN_CYCLES  = lad_pkg::WIN_T1_CYCLES
) (
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Line mode.
    input  wire logic        e1_mode_in,
    input  wire logic        esf_mode_in,
    // Receive framer indications.
    input  wire logic        frame_sync_in,
    input  wire logic        mf_sync_in,
    input  wire logic        a_bit_valid_in,
    input  wire logic        a_bit_in,
    input  wire logic        y_bit_valid_in,
    input  wire logic        y_bit_in,
    input  wire logic        rx_bit_valid_in,
    input  wire logic        rx_bit_in,
    input  wire logic        slot16_valid_in,
    input  wire logic [7:0]  slot16_octet_in,
    input  wire logic        dl_bit_valid_in,
    input  wire logic        dl_bit_in,
    // AXI4-Lite write.
    input  wire logic [11:0] s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    // AXI4-Lite read.
    input  wire logic [11:0] s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // Alarm outputs.
    output logic [6:0]       alarm_state_out,
    output logic             irq_n_out
);
    localparam logic [24:0] E1_LAST = 25'(E1_HOLD_CYCLES - 1);
    localparam logic [24:0] T1_LAST = 25'(T1_WIN_CYCLES - 1);
    localparam int          E1_LAST_I = int'(E1_HOLD_CYCLES - 1);

    typedef struct packed {
        logic        awready;
        logic        aw_full;
        logic [11:0] aw_addr;
        logic        wready;
        logic        w_full;
        logic [31:0] w_data;
        logic        w_lane0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [7:0]  mask;
        logic [7:0]  crit;
        logic [7:0]  cf_dth;
        logic [7:0]  cf_cth;
        logic [7:0]  yel_dth;
        logic [7:0]  yel_cth;
        logic [7:0]  ao_dth;
        logic [7:0]  ao_cth;
        logic [6:0]  alm;
        logic [6:0]  evt;
        logic        irq_n;
        logic [2:0]  rai_cnt;
        logic [1:0]  mf_cnt;
        logic [24:0] cf_cyc;
        logic [7:0]  cf_win;
        logic [24:0] t40;
        logic [8:0]  ao_bits;
        logic [6:0]  ao_zero;
        logic        ao_prev_low;
        logic [7:0]  ao_win;
        logic [15:0] yel_sh;
        logic [3:0]  yel_cnt;
        logic [7:0]  yel_win;
        logic [3:0]  s16_frm;
        logic [2:0]  s16_zero;
        logic        s16_prev_low;
        logic [3:0]  s16_run;
    } lad_state_t;

    lad_state_t  s_r;
    lad_state_t  s_nxt;
    logic [31:0] rd_val;
    logic        rd_ok;
    logic        wr_ok;
    logic        wr_go;
    logic [6:0]  clr_mask;
    logic        tick40;
    logic [6:0]  ao_lim;
    logic [6:0]  ao_z;
    logic        ao_low;
    logic [3:0]  s16_sum;
    logic [2:0]  s16_z;
    logic        s16_low;
    logic [15:0] yel_sh;
    logic [8:0]  step;
    logic [24:0] cf_last;

    // Consecutive-window counter shared by all threshold alarms; a zero threshold acts as one.
    function automatic logic [8:0] win_step(input logic opp, input logic [7:0] win,
                                            input logic [7:0] thr);
        logic [7:0] lim;
        lim = (thr == 8'h00) ? 8'h01 : thr;
        if (!opp) begin
            win_step = 9'h000;
        end else if (win + 8'h01 >= lim) begin
            win_step = {1'b1, 8'h00};
        end else begin
            win_step = {1'b0, win + 8'h01};
        end
    endfunction

    function automatic logic [3:0] zeros8(input logic [7:0] o);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 8; i++) begin
            c = c + {3'h0, ~o[i]};
        end
        return c;
    endfunction

    always_comb begin
        rd_val = 32'h0;
        rd_ok  = 1'b1;
        case ({s_axi_araddr_in[11:2], 2'h0})
            lad_pkg::A_STATE: rd_val = {25'h0, s_r.alm};
            lad_pkg::A_MASK:  rd_val = {24'h0, s_r.mask};
            lad_pkg::A_EVT:   rd_val = {25'h0, s_r.evt};
            lad_pkg::A_CRIT:  rd_val = {24'h0, e1_mode_in ? s_r.crit : s_r.cf_dth};
            lad_pkg::A_CFC:   rd_val = {24'h0, s_r.cf_cth};
            lad_pkg::A_YD:    rd_val = {24'h0, s_r.yel_dth};
            lad_pkg::A_YC:    rd_val = {24'h0, s_r.yel_cth};
            lad_pkg::A_AD:    rd_val = {24'h0, s_r.ao_dth};
            lad_pkg::A_AC:    rd_val = {24'h0, s_r.ao_cth};
            default:          rd_ok  = 1'b0;
        endcase
    end

    always_comb begin
        s_nxt    = s_r;
        wr_go    = s_r.aw_full && s_r.w_full && !s_r.bvalid;
        wr_ok    = 1'b1;
        clr_mask = 7'h00;
        tick40   = (s_r.t40 == T1_LAST);
        ao_lim   = e1_mode_in ? lad_pkg::AO_E1_LIM : lad_pkg::AO_T1_LIM;
        ao_z     = s_r.ao_zero;
        ao_low   = 1'b0;
        s16_sum  = {1'b0, s_r.s16_zero} + zeros8(slot16_octet_in);
        s16_z    = (s16_sum >= {1'b0, lad_pkg::S16_LIM}) ? lad_pkg::S16_LIM : s16_sum[2:0];
        s16_low  = (s16_z < lad_pkg::S16_LIM);
        yel_sh   = {s_r.yel_sh[14:0], dl_bit_in};
        step     = 9'h000;
        cf_last  = e1_mode_in ? E1_LAST : T1_LAST;

        // Register bus: address and data are taken in either order, one write at a time.
        if (s_r.awready && s_axi_awvalid_in) begin
            s_nxt.awready = 1'b0;
            s_nxt.aw_full = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr_in;
        end
        if (s_r.wready && s_axi_wvalid_in) begin
            s_nxt.wready  = 1'b0;
            s_nxt.w_full  = 1'b1;
            s_nxt.w_data  = s_axi_wdata_in;
            s_nxt.w_lane0 = s_axi_wstrb_in[0];
        end
        if (wr_go) begin
            s_nxt.aw_full = 1'b0;
            s_nxt.w_full  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            case ({s_r.aw_addr[11:2], 2'h0})
                lad_pkg::A_STATE: wr_ok = 1'b1;
                lad_pkg::A_MASK:  if (s_r.w_lane0) s_nxt.mask = s_r.w_data[7:0];
                lad_pkg::A_EVT:   if (s_r.w_lane0) clr_mask = s_r.w_data[6:0];
                lad_pkg::A_CRIT: begin
                    if (s_r.w_lane0 && e1_mode_in) s_nxt.crit = s_r.w_data[7:0];
                    if (s_r.w_lane0 && !e1_mode_in) s_nxt.cf_dth = s_r.w_data[7:0];
                end
                lad_pkg::A_CFC:   if (s_r.w_lane0) s_nxt.cf_cth = s_r.w_data[7:0];
                lad_pkg::A_YD:    if (s_r.w_lane0) s_nxt.yel_dth = s_r.w_data[7:0];
                lad_pkg::A_YC:    if (s_r.w_lane0) s_nxt.yel_cth = s_r.w_data[7:0];
                lad_pkg::A_AD:    if (s_r.w_lane0) s_nxt.ao_dth = s_r.w_data[7:0];
                lad_pkg::A_AC:    if (s_r.w_lane0) s_nxt.ao_cth = s_r.w_data[7:0];
                default:          wr_ok = 1'b0;
            endcase
            s_nxt.bresp = wr_ok ? lad_pkg::RESP_OKAY : lad_pkg::RESP_SLVERR;
        end
        if (s_r.bvalid && s_axi_bready_in) begin
            s_nxt.bvalid  = 1'b0;
            s_nxt.awready = 1'b1;
            s_nxt.wready  = 1'b1;
        end
        if (s_r.arready && s_axi_arvalid_in) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid  = 1'b1;
            s_nxt.rdata   = rd_val;
            s_nxt.rresp   = rd_ok ? lad_pkg::RESP_OKAY : lad_pkg::RESP_SLVERR;
        end
        if (s_r.rvalid && s_axi_rready_in) begin
            s_nxt.rvalid  = 1'b0;
            s_nxt.arready = 1'b1;
        end

        // Remote alarm on the A bit, judged only in basic frame sync.
        if (e1_mode_in && frame_sync_in && a_bit_valid_in) begin
            if (!a_bit_in) begin
                s_nxt.rai_cnt = 3'h0;
                s_nxt.alm[lad_pkg::B_RAI] = 1'b0;
            end else begin
                if (s_r.rai_cnt != lad_pkg::RAI_LAST) s_nxt.rai_cnt = s_r.rai_cnt + 3'h1;
                if (s_r.crit[lad_pkg::C_RAI] || s_r.rai_cnt == lad_pkg::RAI_LAST) begin
                    s_nxt.alm[lad_pkg::B_RAI] = 1'b1;
                end
            end
        end

        // Multiframe remote alarm on the Y bit.
        if (e1_mode_in && mf_sync_in && y_bit_valid_in) begin
            if (!y_bit_in) begin
                s_nxt.mf_cnt = 2'h0;
                s_nxt.alm[lad_pkg::B_MF] = 1'b0;
            end else begin
                if (s_r.mf_cnt != lad_pkg::MF_LAST) s_nxt.mf_cnt = s_r.mf_cnt + 2'h1;
                if (s_r.mf_cnt == lad_pkg::MF_LAST) s_nxt.alm[lad_pkg::B_MF] = 1'b1;
            end
        end

        // Carrier failure: the opposite condition must persist without a break.
        if (s_r.alm[lad_pkg::B_CF] ? !frame_sync_in : frame_sync_in) begin
            s_nxt.cf_cyc = 25'h0;
            s_nxt.cf_win = 8'h00;
        end else if (s_r.cf_cyc >= cf_last) begin
            s_nxt.cf_cyc = 25'h0;
            step = win_step(1'b1, s_r.cf_win,
                            e1_mode_in ? 8'h01 :
                            (s_r.alm[lad_pkg::B_CF] ? s_r.cf_cth : s_r.cf_dth));
            s_nxt.cf_win = step[7:0];
            if (step[8]) s_nxt.alm[lad_pkg::B_CF] = !s_r.alm[lad_pkg::B_CF];
        end else begin
            s_nxt.cf_cyc = s_r.cf_cyc + 25'h1;
        end

        // Free-running 40 ms window for the T1 criteria.
        s_nxt.t40 = tick40 ? 25'h0 : s_r.t40 + 25'h1;

        // All-ones: zeros counted in fixed windows, sync ignored except by criterion 0.
        if (rx_bit_valid_in) begin
            ao_z = (s_r.ao_zero >= ao_lim) ? ao_lim : s_r.ao_zero + {6'h00, ~rx_bit_in};
            s_nxt.ao_zero = ao_z;
        end
        ao_low = (ao_z < ao_lim);
        if (e1_mode_in) begin
            if (rx_bit_valid_in) s_nxt.ao_bits = s_r.ao_bits + 9'h001;
            if (rx_bit_valid_in && s_r.ao_bits == lad_pkg::AO_LAST_BIT) begin
                s_nxt.ao_bits = 9'h000;
                s_nxt.ao_zero = 7'h00;
                s_nxt.ao_prev_low = ao_low;
                if (!s_r.crit[lad_pkg::C_AO]) begin
                    if (ao_low && !frame_sync_in) s_nxt.alm[lad_pkg::B_AO] = 1'b1;
                    if (!ao_low) s_nxt.alm[lad_pkg::B_AO] = 1'b0;
                end else begin
                    if (ao_low && s_r.ao_prev_low) s_nxt.alm[lad_pkg::B_AO] = 1'b1;
                    if (!ao_low && !s_r.ao_prev_low) s_nxt.alm[lad_pkg::B_AO] = 1'b0;
                end
            end
        end else if (tick40) begin
            s_nxt.ao_zero = 7'h00;
            step = win_step(s_r.alm[lad_pkg::B_AO] ? !ao_low : ao_low, s_r.ao_win,
                            s_r.alm[lad_pkg::B_AO] ? s_r.ao_cth : s_r.ao_dth);
            s_nxt.ao_win = step[7:0];
            if (step[8]) s_nxt.alm[lad_pkg::B_AO] = !s_r.alm[lad_pkg::B_AO];
        end

        // Slot 16 all-ones and loss, per received slot 16 octet in frame sync.
        if (e1_mode_in && frame_sync_in && slot16_valid_in) begin
            s_nxt.s16_frm  = s_r.s16_frm + 4'h1;
            s_nxt.s16_zero = s16_z;
            if (s_r.s16_frm == lad_pkg::S16_LAST) begin
                s_nxt.s16_zero     = 3'h0;
                s_nxt.s16_prev_low = s16_low;
                if (s16_low && s_r.s16_prev_low) s_nxt.alm[lad_pkg::B_S16A] = 1'b1;
                if (!s16_low) s_nxt.alm[lad_pkg::B_S16A] = 1'b0;
            end
            if (s_r.alm[lad_pkg::B_S16Z] ? (slot16_octet_in == 8'h00)
                                         : (slot16_octet_in != 8'h00)) begin
                s_nxt.s16_run = 4'h0;
            end else if (s_r.s16_run == lad_pkg::S16_LAST) begin
                s_nxt.s16_run = 4'h0;
                s_nxt.alm[lad_pkg::B_S16Z] = !s_r.alm[lad_pkg::B_S16Z];
            end else begin
                s_nxt.s16_run = s_r.s16_run + 4'h1;
            end
        end

        // ESF yellow: 0xff00 words on the data link, MSB first, counted per window.
        if (dl_bit_valid_in) begin
            s_nxt.yel_sh = yel_sh;
            if (yel_sh == lad_pkg::YEL_PAT && s_r.yel_cnt <= lad_pkg::YEL_LIM) begin
                s_nxt.yel_cnt = s_r.yel_cnt + 4'h1;
            end
        end
        if (tick40) begin
            s_nxt.yel_cnt = 4'h0;
            step = win_step(s_r.alm[lad_pkg::B_YEL] ? (s_r.yel_cnt <= lad_pkg::YEL_LIM)
                                                     : (s_r.yel_cnt > lad_pkg::YEL_LIM),
                            s_r.yel_win,
                            s_r.alm[lad_pkg::B_YEL] ? s_r.yel_cth : s_r.yel_dth);
            s_nxt.yel_win = step[7:0];
            if (step[8]) s_nxt.alm[lad_pkg::B_YEL] = !s_r.alm[lad_pkg::B_YEL];
        end

        // Alarms of the other line mode are held clear so stale state cannot interrupt.
        if (!e1_mode_in) begin
            s_nxt.alm[lad_pkg::B_RAI]  = 1'b0;
            s_nxt.alm[lad_pkg::B_MF]   = 1'b0;
            s_nxt.alm[lad_pkg::B_S16A] = 1'b0;
            s_nxt.alm[lad_pkg::B_S16Z] = 1'b0;
        end
        if (e1_mode_in || !esf_mode_in) begin
            s_nxt.alm[lad_pkg::B_YEL] = 1'b0;
            s_nxt.yel_win             = 8'h00;
        end

        s_nxt.evt   = (s_r.evt & ~clr_mask) | (s_nxt.alm ^ s_r.alm);
        s_nxt.irq_n = ~|(s_nxt.evt & s_nxt.mask[6:0]);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r         <= '0;
            s_r.awready <= 1'b1;
            s_r.wready  <= 1'b1;
            s_r.arready <= 1'b1;
            s_r.irq_n   <= 1'b1;
            s_r.mask    <= lad_pkg::MASK_RST;
            s_r.crit    <= lad_pkg::CRIT_RST;
            s_r.cf_dth  <= lad_pkg::THR_RST;
            s_r.cf_cth  <= lad_pkg::THR_RST;
            s_r.yel_dth <= lad_pkg::THR_RST;
            s_r.yel_cth <= lad_pkg::THR_RST;
            s_r.ao_dth  <= lad_pkg::THR_RST;
            s_r.ao_cth  <= lad_pkg::THR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready_out = s_r.awready;
    assign s_axi_wready_out  = s_r.wready;
    assign s_axi_bresp_out   = s_r.bresp;
    assign s_axi_bvalid_out  = s_r.bvalid;
    assign s_axi_arready_out = s_r.arready;
    assign s_axi_rdata_out   = s_r.rdata;
    assign s_axi_rresp_out   = s_r.rresp;
    assign s_axi_rvalid_out  = s_r.rvalid;
    assign alarm_state_out   = s_r.alm;
    assign irq_n_out         = s_r.irq_n;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence seq_a_seen;
        e1_mode_in && frame_sync_in && a_bit_valid_in;
    endsequence
    sequence seq_fourth_one;
        seq_a_seen ##0 a_bit_in && s_r.rai_cnt == lad_pkg::RAI_LAST;
    endsequence

    AST_RAI_FOUR: assert property (seq_fourth_one |=> s_r.alm[lad_pkg::B_RAI])
        else $error("Remote alarm missed after four ones.");
    AST_RAI_EARLY: assert property (seq_a_seen ##0 a_bit_in && !s_r.crit[lad_pkg::C_RAI]
        && s_r.rai_cnt < lad_pkg::RAI_LAST && !s_r.alm[lad_pkg::B_RAI]
        |=> !s_r.alm[lad_pkg::B_RAI])
        else $error("Remote alarm set too early.");
    AST_RAI_FAST: assert property (seq_a_seen ##0 a_bit_in && s_r.crit[lad_pkg::C_RAI]
        |=> s_r.alm[lad_pkg::B_RAI])
        else $error("Remote alarm missed under fast criterion.");
    AST_RAI_CLEAR: assert property (seq_a_seen ##0 !a_bit_in
        |=> !s_r.alm[lad_pkg::B_RAI])
        else $error("Remote alarm not cleared by a zero.");
    AST_RAI_NOSYNC: assert property (e1_mode_in && !frame_sync_in
        |=> $stable(s_r.alm[lad_pkg::B_RAI]))
        else $error("Remote alarm moved out of frame sync.");
    AST_MF_SET: assert property (e1_mode_in && mf_sync_in && y_bit_valid_in && y_bit_in
        && s_r.mf_cnt == lad_pkg::MF_LAST |=> s_r.alm[lad_pkg::B_MF])
        else $error("Multiframe remote alarm missed.");
    AST_CF_E1: assert property (e1_mode_in && !frame_sync_in && !s_r.alm[lad_pkg::B_CF]
        && s_r.cf_cyc == 25'(E1_LAST_I) |=> s_r.alm[lad_pkg::B_CF])
        else $error("Carrier failure not declared after the hold time.");
    AST_AO_WIN: assert property (e1_mode_in && rx_bit_valid_in
        && s_r.ao_bits == lad_pkg::AO_LAST_BIT |=> s_r.ao_bits == 9'h000)
        else $error("All-ones window did not restart.");
    AST_EVT_SET: assert property (s_r.alm != $past(s_r.alm)
        |-> ((s_r.alm ^ $past(s_r.alm)) & ~s_r.evt) == 7'h00)
        else $error("State change did not set its event.");
    AST_EVT_CLR: assert property (wr_go && {s_r.aw_addr[11:2], 2'h0} == lad_pkg::A_EVT
        && s_r.w_lane0 && s_r.w_data[0] && s_nxt.alm[0] == s_r.alm[0]
        |=> !s_r.evt[0])
        else $error("Event latch not cleared by a one.");
    AST_IRQ: assert property (##1 irq_n_out == !(|(s_r.evt & s_r.mask[6:0])))
        else $error("Interrupt output disagrees with events.");
endmodule
`default_nettype wire

//--- lad_pkg.sv
`default_nettype none
package lad_pkg;
    // Clock and documented times.
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned CF_E1_MS      = 100;
    localparam int unsigned WIN_T1_MS     = 40;
    localparam int unsigned CF_E1_CYCLES  = (CLK_HZ / 1000) * CF_E1_MS;
    localparam int unsigned WIN_T1_CYCLES = (CLK_HZ / 1000) * WIN_T1_MS;
    localparam int unsigned CNT_W         = 25;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0]  IDX_STATE = 8'hb9;
    localparam logic [7:0]  IDX_MASK  = 8'hba;
    localparam logic [7:0]  IDX_EVT   = 8'hbb;
    localparam logic [7:0]  IDX_CRIT  = 8'hbc;
    localparam logic [7:0]  IDX_CFC   = 8'hbd;
    localparam logic [7:0]  IDX_YD    = 8'hbe;
    localparam logic [7:0]  IDX_YC    = 8'hbf;
    localparam logic [7:0]  IDX_AD    = 8'hc0;
    localparam logic [7:0]  IDX_AC    = 8'hc1;
    localparam int unsigned AW        = 12;
    localparam logic [11:0] A_STATE   = {2'h0, IDX_STATE, 2'h0};
    localparam logic [11:0] A_MASK    = {2'h0, IDX_MASK, 2'h0};
    localparam logic [11:0] A_EVT     = {2'h0, IDX_EVT, 2'h0};
    localparam logic [11:0] A_CRIT    = {2'h0, IDX_CRIT, 2'h0};
    localparam logic [11:0] A_CFC     = {2'h0, IDX_CFC, 2'h0};
    localparam logic [11:0] A_YD      = {2'h0, IDX_YD, 2'h0};
    localparam logic [11:0] A_YC      = {2'h0, IDX_YC, 2'h0};
    localparam logic [11:0] A_AD      = {2'h0, IDX_AD, 2'h0};
    localparam logic [11:0] A_AC      = {2'h0, IDX_AC, 2'h0};

    // Alarm bit positions in state, event and mask registers.
    localparam int unsigned NALM   = 7;
    localparam int unsigned B_RAI  = 0;
    localparam int unsigned B_MF   = 1;
    localparam int unsigned B_CF   = 2;
    localparam int unsigned B_AO   = 3;
    localparam int unsigned B_S16A = 4;
    localparam int unsigned B_S16Z = 5;
    localparam int unsigned B_YEL  = 6;
    localparam int unsigned C_RAI  = 0;
    localparam int unsigned C_AO   = 1;

    // Reset values.
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] CRIT_RST = 8'h00;
    localparam logic [7:0] THR_RST  = 8'h01;

    // Detection thresholds.
    localparam logic [2:0]  RAI_LAST    = 3'h3;
    localparam logic [1:0]  MF_LAST     = 2'h2;
    localparam logic [8:0]  AO_LAST_BIT = 9'h1ff;
    localparam logic [6:0]  AO_E1_LIM   = 7'h03;
    localparam logic [6:0]  AO_T1_LIM   = 7'h3d;
    localparam logic [3:0]  S16_LAST    = 4'hf;
    localparam logic [2:0]  S16_LIM     = 3'h4;
    localparam logic [15:0] YEL_PAT     = 16'hff00;
    localparam logic [3:0]  YEL_LIM     = 4'h7;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- lad_framer_model.sv
`default_nettype none
module lad_framer_model (
    // Clock and reset.
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Overhead values to send.
    input  wire logic       a_in,
    input  wire logic       y_in,
    input  wire logic       rx_in,
    input  wire logic [7:0] oct_in,
    // Strobed framer outputs.
    output logic            stb_out,
    output logic            a_out,
    output logic            y_out,
    output logic            rx_out,
    output logic [7:0]      oct_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_r;
    // Between strobes the lines carry the inverse, so a stale value is never mistaken.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) cnt_r <= 2'h0;
        else cnt_r <= cnt_r + 2'h1;
    end
    assign stb_out = (cnt_r == 2'h3);
    assign a_out   = stb_out ? a_in : ~a_in;
    assign y_out   = stb_out ? y_in : ~y_in;
    assign rx_out  = stb_out ? rx_in : ~rx_in;
    assign oct_out = stb_out ? oct_in : ~oct_in;
endmodule
`default_nettype wire

//--- line_alarm_detector_tb_top.sv
`default_nettype none
module line_alarm_detector_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rst_n_in, frame_sync_in, mf_sync_in, stb, a_bit_in, y_bit_in, rx_bit_in;
    logic a, y, rx, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
    logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
    logic s_axi_rvalid_out, s_axi_rready_in, irq_n_out;
    logic [7:0] oct, slot16_octet_in;
    logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
    logic [6:0] alarm_state_out;
    logic e1;
    logic [3:0] strb;
    int n_errors, compares, cyc;
    lad_framer_model lad_framer_model_inst (.clk_in, .rst_n_in, .a_in(a), .y_in(y),
        .rx_in(rx), .oct_in(oct), .stb_out(stb), .a_out(a_bit_in), .y_out(y_bit_in),
        .rx_out(rx_bit_in), .oct_out(slot16_octet_in));
    lad_line_alarm_detector #(.E1_HOLD_CYCLES(64), .T1_WIN_CYCLES(32))
        lad_line_alarm_detector_inst (.clk_in, .rst_n_in, .e1_mode_in(e1),
        .esf_mode_in(1'b0), .frame_sync_in, .mf_sync_in, .a_bit_valid_in(stb), .a_bit_in,
        .y_bit_valid_in(stb), .y_bit_in, .rx_bit_valid_in(stb), .rx_bit_in,
        .slot16_valid_in(stb), .slot16_octet_in, .dl_bit_valid_in(1'b0), .dl_bit_in(1'b0),
        .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
        .s_axi_wstrb_in(strb), .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
        .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
        .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
        .s_axi_rready_in, .alarm_state_out, .irq_n_out);
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic summarize;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // The ceiling allows more than twice the expected run, since the all-ones wait dominates.
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 12000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
        @(posedge clk_in);
        {s_axi_awaddr_in, s_axi_wdata_in} <= {ad, dt};
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        do begin
            @(posedge clk_in);
            if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (!s_axi_bvalid_out);
        r = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] ad);
        @(posedge clk_in);
        {s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} <= {ad, 2'h3};
        do begin
            @(posedge clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (!s_axi_rvalid_out);
        {d, r} = {s_axi_rdata_out, s_axi_rresp_out};
        s_axi_rready_in <= 1'b0;
    endtask
    initial begin
        {rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 4'h0;
        {s_axi_arvalid_in, s_axi_rready_in, a, y, rx} = 5'h0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 56'h0;
        {frame_sync_in, mf_sync_in, oct} = {2'h3, 8'hff};
        {e1, strb} = 5'h1f;
        wt(3);
        rst_n_in <= 1'b1;
        rd(lad_pkg::A_MASK); chk(d, 32'h0);
        rd(12'h000); chk(r, lad_pkg::RESP_SLVERR);
        wr(lad_pkg::A_MASK, 32'h3f);
        chk(r, lad_pkg::RESP_OKAY);
        a <= 1'b1; wt(10); chk(alarm_state_out[0], 1'b0);
        wt(8); chk(alarm_state_out[0], 1'b1);
        chk(irq_n_out, 1'b0);
        rd(lad_pkg::A_EVT); chk(d, 32'h1);
        wr(lad_pkg::A_EVT, 32'h1); rd(lad_pkg::A_EVT); chk(d, 32'h0);
        chk(irq_n_out, 1'b1);
        a <= 1'b0; wt(8); chk(alarm_state_out[0], 1'b0);
        wr(lad_pkg::A_CRIT, 32'h1); a <= 1'b1; wt(7); chk(alarm_state_out[0], 1'b1);
        {frame_sync_in, a} <= 2'h0; wt(8); chk(alarm_state_out[0], 1'b1);
        wt(70); chk(alarm_state_out[2], 1'b1);
        rx <= 1'b1; wt(4200); chk(alarm_state_out[3], 1'b1);
        {frame_sync_in, y} <= 2'h3; wt(6); chk(alarm_state_out[1], 1'b0);
        wt(10); chk(alarm_state_out[1], 1'b1);
        wt(130);
        chk(alarm_state_out[4], 1'b1);
        oct <= 8'h00; wt(80); chk(alarm_state_out[5], 1'b1);
        chk(alarm_state_out[2], 1'b0);
        chk(alarm_state_out[4], 1'b0);
        wr(12'h000, 32'h0);
        chk(r, lad_pkg::RESP_SLVERR);
        strb <= 4'h0;
        wr(lad_pkg::A_MASK, 32'h0);
        strb <= 4'hf;
        rd(lad_pkg::A_MASK);
        chk(d, 32'h3f);
        e1 <= 1'b0;
        wr(lad_pkg::A_CRIT, 32'h2);
        rd(lad_pkg::A_CRIT);
        chk(d, 32'h2);
        e1 <= 1'b1;
        rd(lad_pkg::A_CRIT);
        chk(d, 32'h1);
        summarize();
    end
endmodule
`default_nettype wire
